// >>> logic/adc_cal_pkg.sv
// Purpose: shared constants and carriers for the calibration control block
// Assumes: 8-bit register port, one clock
// Notes:   offsets are byte addresses of the serial register port
package adc_cal_pkg;
	localparam logic [7:0] RUN_CONTROL_ADDR    = 8'h61;
	localparam logic [7:0] MODE_CONFIG_ADDR    = 8'h62;
	localparam logic [7:0] OFFSET_REF_ADDR     = 8'h65;
	localparam logic [7:0] AVERAGING_ADDR      = 8'h68;
	localparam logic [7:0] CAL_STATUS_ADDR     = 8'h6a;

	localparam logic [7:0] RUN_CONTROL_RESET   = 8'h01;
	localparam logic [7:0] MODE_CONFIG_RESET   = 8'h01;
	localparam logic [7:0] OFFSET_REF_RESET    = 8'h01;
	localparam logic [7:0] AVERAGING_RESET     = 8'h61;

	localparam int RUN_BIT                     = 0;
	localparam int FG_CAL_BIT                  = 0;
	localparam int BG_CAL_BIT                  = 1;
	localparam int FG_OFFSET_BIT               = 2;
	localparam int BG_OFFSET_BIT               = 3;
	localparam int OFFSET_REF_BIT              = 2;
	localparam int LIN_AVG_LSB                 = 0;
	localparam int OFFSET_AVG_LSB              = 4;
	localparam int AVG_WIDTH                   = 3;
	localparam int FG_FINISHED_BIT             = 0;

	localparam logic [15:0] FG_BASE_CYCLES     = 16'h0010;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_s;

	typedef enum logic [2:0] {
		CAL_HELD,
		CAL_CLEAR_VALUES,
		FOREGROUND_CAL_ON_LINEARITY,
		FOREGROUND_CAL_ON_OFFSET,
		CAL_RUNNING
	} cal_state_e;
endpackage : adc_cal_pkg

// >>> logic/adc_calibration_control.sv
// Purpose: register file and sequencing of the calibration engine
// Assumes: register requests synchronous to CLOCK, one request per cycle
// Notes:   engine follows the run bit; settings are read live from the registers
// What this block does
// - run bit high runs calibration, low holds it in reset; resets to 1
// - clearing run bit also resets digital and serial link clock dividers
// - setting run bit again reruns calibration with the new settings
// - bit 3 enables background offset calibration, only with background on; reset 0
// - bit 2 enables foreground offset calibration, needs foreground selected; reset 0
// - bit 1 enables background calibration; reset 0
// - bit 0: values always reset, then foreground runs if 1, skipped if 0
// - offset reference 0 calibrates offset toward mid-code
// - offset reference 1 matches primary offsets to the spare converter
// - bits 6:4 set offset averaging depth; reset 6; larger means longer
// - bits 2:0 set linearity averaging depth; reset 1; larger means longer
// - foreground finished status rises when foreground completes or is skipped
`timescale 1ns/1ps
module adc_calibration_control #(
	parameter logic [15:0] FG_BASE = adc_cal_pkg::FG_BASE_CYCLES
) (
	input  wire logic                 CLOCK,
	input  wire logic                 SYS_RST,
	input  wire adc_cal_pkg::reg_req_s REG_REQ,
	output logic [7:0]                REG_RDATA,
	output logic                      REG_RVALID,
	output logic                      CAL_ENGINE_RESET,
	output logic                      DIVIDER_RESET,
	output logic                      CAL_VALUES_CLEAR,
	output logic                      FG_LINEARITY_ACTIVE,
	output logic                      FG_OFFSET_ACTIVE,
	output logic                      BG_CAL_ACTIVE,
	output logic                      BG_OFFSET_ACTIVE,
	output logic                      OFFSET_REF_SPARE,
	output logic [2:0]                OFFSET_AVG_DEPTH,
	output logic [2:0]                LIN_AVG_DEPTH,
	output logic                      FG_FINISHED
);
	logic [7:0]              run_control;
	logic [7:0]              mode_config;
	logic [7:0]              offset_ref;
	logic [7:0]              averaging;
	adc_cal_pkg::cal_state_e state;
	adc_cal_pkg::cal_state_e next_state;
	logic [15:0]             phase_count;
	logic [15:0]             lin_target;
	logic [15:0]             os_target;
	logic                    run_bit;
	logic                    fg_bit;
	logic                    phase_end;

	assign run_bit    = run_control[adc_cal_pkg::RUN_BIT];
	assign fg_bit     = mode_config[adc_cal_pkg::FG_CAL_BIT];
	// depth 7 gives FG_BASE*128 cycles; keep FG_BASE small enough for 16 bits
	assign lin_target = FG_BASE << LIN_AVG_DEPTH;
	assign os_target  = FG_BASE << OFFSET_AVG_DEPTH;
	assign phase_end  = (state == adc_cal_pkg::FOREGROUND_CAL_ON_LINEARITY) ? (phase_count == lin_target - 16'h0001)
	                                                             : (phase_count == os_target - 16'h0001);

	// register file: reserved bits stored as written
	always_ff @(posedge CLOCK)
	begin
		if (SYS_RST)
		begin
			run_control <= adc_cal_pkg::RUN_CONTROL_RESET;
			mode_config <= adc_cal_pkg::MODE_CONFIG_RESET;
			offset_ref  <= adc_cal_pkg::OFFSET_REF_RESET;
			averaging   <= adc_cal_pkg::AVERAGING_RESET;
		end
		else if (REG_REQ.wr)
		begin
			unique case (REG_REQ.addr)
				adc_cal_pkg::RUN_CONTROL_ADDR: run_control <= REG_REQ.wdata;
				adc_cal_pkg::MODE_CONFIG_ADDR: mode_config <= REG_REQ.wdata;
				adc_cal_pkg::OFFSET_REF_ADDR:  offset_ref  <= REG_REQ.wdata;
				adc_cal_pkg::AVERAGING_ADDR:   averaging   <= REG_REQ.wdata;
				default:                       ;
			endcase
		end
	end

	always_ff @(posedge CLOCK)
	begin
		if (SYS_RST)
		begin
			REG_RDATA  <= 8'h00;
			REG_RVALID <= 1'b0;
		end
		else
		begin
			REG_RVALID <= REG_REQ.rd;
			unique case (REG_REQ.addr)
				adc_cal_pkg::RUN_CONTROL_ADDR: REG_RDATA <= run_control;
				adc_cal_pkg::MODE_CONFIG_ADDR: REG_RDATA <= mode_config;
				adc_cal_pkg::OFFSET_REF_ADDR:  REG_RDATA <= offset_ref;
				adc_cal_pkg::AVERAGING_ADDR:   REG_RDATA <= averaging;
				adc_cal_pkg::CAL_STATUS_ADDR:  REG_RDATA <= {7'h00, FG_FINISHED};
				default:                       REG_RDATA <= 8'h00;
			endcase
		end
	end

	// settings go out straight from the register flops
	assign OFFSET_REF_SPARE = offset_ref[adc_cal_pkg::OFFSET_REF_BIT];
	assign OFFSET_AVG_DEPTH = averaging[adc_cal_pkg::OFFSET_AVG_LSB +: adc_cal_pkg::AVG_WIDTH];
	assign LIN_AVG_DEPTH    = averaging[adc_cal_pkg::LIN_AVG_LSB +: adc_cal_pkg::AVG_WIDTH];

	always_comb
	begin
		next_state = state;
		if (!run_bit)
			next_state = adc_cal_pkg::CAL_HELD;
		else
		begin
			unique case (state)
				adc_cal_pkg::CAL_HELD:
					next_state = adc_cal_pkg::CAL_CLEAR_VALUES;
				adc_cal_pkg::CAL_CLEAR_VALUES:
					next_state = fg_bit ? adc_cal_pkg::FOREGROUND_CAL_ON_LINEARITY : adc_cal_pkg::CAL_RUNNING;
				adc_cal_pkg::FOREGROUND_CAL_ON_LINEARITY:
					if (phase_end)
						next_state = mode_config[adc_cal_pkg::FG_OFFSET_BIT] ? adc_cal_pkg::FOREGROUND_CAL_ON_OFFSET
						                                                     : adc_cal_pkg::CAL_RUNNING;
				adc_cal_pkg::FOREGROUND_CAL_ON_OFFSET:
					if (phase_end)
						next_state = adc_cal_pkg::CAL_RUNNING;
				adc_cal_pkg::CAL_RUNNING:
					next_state = adc_cal_pkg::CAL_RUNNING;
			endcase
		end
	end

	always_ff @(posedge CLOCK)
	begin
		if (SYS_RST)
			state <= adc_cal_pkg::CAL_HELD;
		else
			state <= next_state;
	end

	always_ff @(posedge CLOCK)
	begin
		if (SYS_RST || next_state != state)
			phase_count <= 16'h0000;
		else
			phase_count <= phase_count + 16'h0001;
	end

	// outputs decoded from next_state so they align with the state register
	always_ff @(posedge CLOCK)
	begin
		if (SYS_RST)
		begin
			CAL_ENGINE_RESET    <= 1'b1;
			DIVIDER_RESET       <= 1'b1;
			CAL_VALUES_CLEAR    <= 1'b0;
			FG_LINEARITY_ACTIVE <= 1'b0;
			FG_OFFSET_ACTIVE    <= 1'b0;
			BG_CAL_ACTIVE       <= 1'b0;
			BG_OFFSET_ACTIVE    <= 1'b0;
			FG_FINISHED         <= 1'b0;
		end
		else
		begin
			CAL_ENGINE_RESET    <= (next_state == adc_cal_pkg::CAL_HELD);
			DIVIDER_RESET       <= (next_state == adc_cal_pkg::CAL_HELD);
			CAL_VALUES_CLEAR    <= (next_state == adc_cal_pkg::CAL_CLEAR_VALUES);
			FG_LINEARITY_ACTIVE <= (next_state == adc_cal_pkg::FOREGROUND_CAL_ON_LINEARITY);
			FG_OFFSET_ACTIVE    <= (next_state == adc_cal_pkg::FOREGROUND_CAL_ON_OFFSET);
			BG_CAL_ACTIVE       <= (next_state == adc_cal_pkg::CAL_RUNNING)
			                       && mode_config[adc_cal_pkg::BG_CAL_BIT];
			// offset tracking is meaningless without the background loop
			BG_OFFSET_ACTIVE    <= (next_state == adc_cal_pkg::CAL_RUNNING)
			                       && mode_config[adc_cal_pkg::BG_CAL_BIT]
			                       && mode_config[adc_cal_pkg::BG_OFFSET_BIT];
			FG_FINISHED         <= (next_state == adc_cal_pkg::CAL_RUNNING);
		end
	end

	logic [15:0] lin_len;
	logic [15:0] os_len;

	always_ff @(posedge CLOCK)
	begin
		if (SYS_RST)
		begin
			lin_len <= 16'h0000;
			os_len  <= 16'h0000;
		end
		else
		begin
			lin_len <= FG_LINEARITY_ACTIVE ? lin_len + 16'h0001 : 16'h0000;
			os_len  <= FG_OFFSET_ACTIVE ? os_len + 16'h0001 : 16'h0000;
		end
	end

	property p_run_low_holds;
		@(posedge CLOCK) disable iff (SYS_RST) !run_bit |=> CAL_ENGINE_RESET && !FG_FINISHED;
	endproperty
	a_run_low_holds: assert property (p_run_low_holds) else $error("engine not held with run bit low");

	property p_divider_tied;
		@(posedge CLOCK) disable iff (SYS_RST) DIVIDER_RESET == CAL_ENGINE_RESET;
	endproperty
	a_divider_tied: assert property (p_divider_tied) else $error("divider reset differs from engine reset");

	property p_divider_held;
		@(posedge CLOCK) disable iff (SYS_RST) !run_bit |=> DIVIDER_RESET;
	endproperty
	a_divider_held: assert property (p_divider_held) else $error("dividers not reset with run bit low");

	property p_rerun;
		@(posedge CLOCK) disable iff (SYS_RST) $rose(run_bit) |=> CAL_VALUES_CLEAR && !CAL_ENGINE_RESET;
	endproperty
	a_rerun: assert property (p_rerun) else $error("run bit set without rerun");

	property p_fg_select;
		@(posedge CLOCK) disable iff (SYS_RST)
			CAL_VALUES_CLEAR && run_bit |=> ($past(fg_bit) ? FG_LINEARITY_ACTIVE : FG_FINISHED);
	endproperty
	a_fg_select: assert property (p_fg_select) else $error("foreground run or skip wrong");

	property p_bg_on;
		@(posedge CLOCK) disable iff (SYS_RST) BG_CAL_ACTIVE |-> FG_FINISHED && $past(mode_config[adc_cal_pkg::BG_CAL_BIT]);
	endproperty
	a_bg_on: assert property (p_bg_on) else $error("background active without enable");

	property p_bg_offset;
		@(posedge CLOCK) disable iff (SYS_RST) BG_OFFSET_ACTIVE |-> BG_CAL_ACTIVE && $past(mode_config[adc_cal_pkg::BG_OFFSET_BIT]);
	endproperty
	a_bg_offset: assert property (p_bg_offset) else $error("background offset without background");

	property p_fg_offset;
		@(posedge CLOCK) disable iff (SYS_RST) $rose(FG_OFFSET_ACTIVE) |-> $past(FG_LINEARITY_ACTIVE) && fg_bit;
	endproperty
	a_fg_offset: assert property (p_fg_offset) else $error("offset phase not after foreground");

	property p_lin_len;
		@(posedge CLOCK) disable iff (SYS_RST) $fell(FG_LINEARITY_ACTIVE) && !CAL_ENGINE_RESET |-> lin_len == lin_target;
	endproperty
	a_lin_len: assert property (p_lin_len) else $error("linearity phase length wrong");

	property p_os_len;
		@(posedge CLOCK) disable iff (SYS_RST) $fell(FG_OFFSET_ACTIVE) && !CAL_ENGINE_RESET |-> os_len == os_target;
	endproperty
	a_os_len: assert property (p_os_len) else $error("offset phase length wrong");

	property p_finished;
		@(posedge CLOCK) disable iff (SYS_RST) $rose(FG_FINISHED) |-> $past(CAL_VALUES_CLEAR || FG_LINEARITY_ACTIVE || FG_OFFSET_ACTIVE);
	endproperty
	a_finished: assert property (p_finished) else $error("finished without foreground end");

	property p_readback;
		@(posedge CLOCK) disable iff (SYS_RST)
			REG_REQ.wr && REG_REQ.addr == adc_cal_pkg::AVERAGING_ADDR |=> averaging == $past(REG_REQ.wdata);
	endproperty
	a_readback: assert property (p_readback) else $error("register did not take written value");

	property p_spare_ref;
		@(posedge CLOCK) disable iff (SYS_RST)
			REG_REQ.wr && REG_REQ.addr == adc_cal_pkg::OFFSET_REF_ADDR
			|=> OFFSET_REF_SPARE == $past(REG_REQ.wdata[adc_cal_pkg::OFFSET_REF_BIT]);
	endproperty
	a_spare_ref: assert property (p_spare_ref) else $error("offset reference select not taken");
endmodule : adc_calibration_control

// >>> sim/test_adc_calibration_control.sv
// Purpose: self-checking bench for the calibration control block
// Assumes: FG_BASE cut to 2 so foreground phases stay short
// Notes:   inputs change at the rising edge, outputs sampled 1 ns later
`timescale 1ns/1ps
module test_adc_calibration_control;
	localparam logic [15:0] BASE = 16'h0002;
	logic                  clock;
	logic                  sys_rst;
	adc_cal_pkg::reg_req_s req;
	logic [7:0]            rdata;
	logic                  rvalid;
	logic                  eng_rst;
	logic                  div_rst;
	logic                  clr;
	logic                  lin_act;
	logic                  os_act;
	logic                  bg_act;
	logic                  bgos_act;
	logic                  spare;
	logic                  finished;
	logic [2:0]            os_depth;
	logic [2:0]            lin_depth;
	logic [7:0]            rd_val;
	int                    mismatches;
	int                    check_count;
	adc_calibration_control #(.FG_BASE(BASE)) adc_calibration_control_inst (
		.CLOCK(clock), .SYS_RST(sys_rst), .REG_REQ(req), .REG_RDATA(rdata), .REG_RVALID(rvalid),
		.CAL_ENGINE_RESET(eng_rst), .DIVIDER_RESET(div_rst), .CAL_VALUES_CLEAR(clr),
		.FG_LINEARITY_ACTIVE(lin_act), .FG_OFFSET_ACTIVE(os_act), .BG_CAL_ACTIVE(bg_act),
		.BG_OFFSET_ACTIVE(bgos_act), .OFFSET_REF_SPARE(spare), .OFFSET_AVG_DEPTH(os_depth),
		.LIN_AVG_DEPTH(lin_depth), .FG_FINISHED(finished));
	initial
	begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	task check(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task final_report;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : final_report
	task reg_write(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clock);
		req <= '0;
	endtask : reg_write
	// read data is registered, so it is looked at one edge after the request is driven
	task reg_read(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clock);
		req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge clock);
		req <= '0;
		#1;
		check({7'h00, rvalid}, 8'h01);
		check(rdata, exp);
	endtask : reg_read
	// counts phase cycles of one run; bounded so a stuck engine cannot hang the run
	task run_and_count(input int e_lin, input int e_os);
		int n_lin;
		int n_os;
		int n_clr;
		n_lin = 0;
		n_os = 0;
		n_clr = 0;
		// serial link enable lives outside and stays off until run is set
		reg_write(8'h61, 8'h01);
		for (int i = 0; i < 600; i++)
		begin
			@(posedge clock);
			#1;
			n_clr += (clr === 1'b1);
			n_lin += (lin_act === 1'b1);
			n_os += (os_act === 1'b1);
			if (finished === 1'b1)
			begin
				check(8'(n_clr), 8'h01);
				check(8'(n_lin), 8'(e_lin));
				check(8'(n_os), 8'(e_os));
				// depth 7 runs past 255 cycles, so the high byte is compared too
				check(8'(n_os >> 8), 8'(e_os >> 8));
				check(8'(n_lin >> 8), 8'(e_lin >> 8));
				return;
			end
		end
		mismatches++;
		$display("timeout waiting for foreground finish");
		final_report();
	endtask : run_and_count
	task test_reset_and_default_run;
		reg_read(8'h61, 8'h01);
		reg_read(8'h62, 8'h01);
		reg_read(8'h65, 8'h01);
		reg_read(8'h68, 8'h61);
		reg_read(8'h70, 8'h00);
		check({5'h00, os_depth}, 8'h06);
		check({5'h00, lin_depth}, 8'h01);
		repeat (40) @(posedge clock);
		#1;
		check({7'h00, eng_rst}, 8'h00);
		check({7'h00, div_rst}, 8'h00);
		reg_read(8'h6a, 8'h01);
		$display("test reset and default run done");
	endtask : test_reset_and_default_run
	task test_stop;
		// link enable is never set here, so the run bit may be cleared
		reg_write(8'h61, 8'h00);
		@(posedge clock);
		#1;
		check({7'h00, eng_rst}, 8'h01);
		check({7'h00, div_rst}, 8'h01);
		check({7'h00, finished}, 8'h00);
		$display("test stop done");
	endtask : test_stop
	// settings changed only while held, then rerun with them
	task test_foreground(input logic [7:0] avg, input int e_lin, input int e_os);
		reg_write(8'h61, 8'h00);
		reg_write(8'h68, avg);
		reg_write(8'h62, 8'h05);
		reg_read(8'h68, avg);
		check({5'h00, os_depth}, {5'h00, avg[6:4]});
		check({5'h00, lin_depth}, {5'h00, avg[2:0]});
		run_and_count(e_lin, e_os);
		check({7'h00, bg_act}, 8'h00);
		$display("test foreground done");
	endtask : test_foreground
	task test_background(input logic [7:0] mode, input logic [7:0] ref_cfg, input logic [7:0] e_flags);
		reg_write(8'h61, 8'h00);
		reg_write(8'h62, mode);
		reg_write(8'h65, ref_cfg);
		run_and_count(0, 0);
		check({5'h00, bg_act, bgos_act, spare}, e_flags);
		$display("test background done");
	endtask : test_background
	initial
	begin
		sys_rst = 1'b1;
		req = '0;
		mismatches = 0;
		check_count = 0;
		repeat (6) @(posedge clock);
		sys_rst <= 1'b0;
		test_reset_and_default_run();
		test_stop();
		test_foreground(8'h21, 4, 8);
		test_foreground(8'h73, 16, 256);
		test_background(8'h0a, 8'h05, 8'h07);
		test_background(8'h08, 8'h01, 8'h00);
		final_report();
	end
endmodule : test_adc_calibration_control
